// file: design/erc_ctrl_bank.sv
`timescale 1ns/100ps
`default_nettype none
module erc_ctrl_bank #(
  parameter int                 ADDR_W         = 16,
  parameter int                 IDX_W          = 8,
  parameter int                 NODE_FIRST     = 0,
  parameter int                 NODE_RECS      = 2,
  parameter erc_pkg::erc_mode_t DUI_MODE       = erc_pkg::CTL_COMBINED,
  parameter erc_pkg::erc_mode_t CFI_MODE       = erc_pkg::CTL_COMBINED,
  parameter erc_pkg::erc_mode_t UE_MODE        = erc_pkg::CTL_COMBINED,
  parameter erc_pkg::erc_mode_t FI_MODE        = erc_pkg::CTL_COMBINED,
  parameter erc_pkg::erc_mode_t UI_MODE        = erc_pkg::CTL_COMBINED,
  parameter erc_pkg::erc_mode_t ED_MODE        = erc_pkg::CTL_COMBINED,
  parameter bit                 HAS_CE_COUNTER = 1'b1,
  parameter bit                 ED_RESET_VAL   = 1'b0,
  parameter bit                 SILENT_CORRECT = 1'b1,
  parameter logic [63:0]        IMPL_MASK      = 64'h0000_0001_0000_0000
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // memory-mapped path
  input  wire logic                 mm_req,
  input  wire logic                 mm_write,
  input  wire logic [ADDR_W-1:0]    mm_addr,
  input  wire logic [63:0]          mm_wdata,
  output logic [63:0]               mm_rdata,
  output logic                      mm_ack,
  output logic                      mm_hit,
  // selected-record window path
  input  wire logic [IDX_W-1:0]     record_pick_index,
  input  wire logic                 sr_req,
  input  wire logic                 sr_write,
  input  wire erc_pkg::erc_view_t   sr_view,
  input  wire logic [63:0]          sr_wdata,
  output logic [63:0]               sr_rdata,
  output logic                      sr_ack,
  // error events from the node datapath
  input  wire erc_pkg::erc_event_t  err_event,
  input  wire logic                 overflow_clear,
  // node controls and signalling
  output logic                      record_log,
  output logic                      recovery_irq,
  output logic                      fault_irq,
  output logic                      abort_resp,
  output logic                      report_enable,
  output logic                      check_gen_enable,
  output logic                      silent_correct_enable,
  output logic                      counter_overflow_flag
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NODE_RECS < 1 || NODE_FIRST < 0) begin : g_bad_node
    $error("node needs at least one record");
  end
  if (NODE_FIRST + NODE_RECS > (1 << IDX_W)) begin : g_bad_idx
    $error("record index too narrow for the node");
  end
  if (NODE_FIRST + NODE_RECS > (1 << (ADDR_W - erc_pkg::REC_SHIFT)))
  begin : g_bad_addr
    $error("address too narrow for the node");
  end
  if (DUI_MODE == erc_pkg::CTL_ALWAYS || CFI_MODE == erc_pkg::CTL_ALWAYS)
  begin : g_bad_fixed
    $error("deferred and corrected controls cannot be fixed on");
  end
  if (ED_MODE == erc_pkg::CTL_SPLIT || ED_MODE == erc_pkg::CTL_ABSENT)
  begin : g_bad_ed
    $error("reporting control is combined or fixed on");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // writable bits of one control: read slot if combined or split, write slot if split
  function automatic logic [63:0] ctl_bits(
    input erc_pkg::erc_mode_t mode,
    input int                 rpos,
    input int                 wpos
  );
    logic [63:0] m;
    m = '0;
    if (mode == erc_pkg::CTL_COMBINED || mode == erc_pkg::CTL_SPLIT) begin
      m[rpos] = 1'b1;
    end
    if (mode == erc_pkg::CTL_SPLIT) begin
      m[wpos] = 1'b1;
    end
    return m;
  endfunction

  // effective enable for one direction
  function automatic logic ctl_en(
    input erc_pkg::erc_mode_t mode,
    input logic [63:0]        r,
    input int                 rpos,
    input int                 wpos,
    input logic               is_write
  );
    logic e;
    e = 1'b0;
    unique case (mode)
      erc_pkg::CTL_ALWAYS:   e = 1'b1;
      erc_pkg::CTL_COMBINED: e = r[rpos];
      erc_pkg::CTL_SPLIT:    e = is_write ? r[wpos] : r[rpos];
      erc_pkg::CTL_ABSENT:   e = 1'b0;
    endcase
    return e;
  endfunction

  // bit-mask merge of a write into the shared copy
  function automatic logic [63:0] merge(
    input logic [63:0] cur,
    input logic [63:0] wd,
    input logic [63:0] m
  );
    return (cur & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // writable mask
  // ----------------------------------------------------------------
  // absent controls and reserved slots never get a storage bit, so
  // they read zero and drop writes without any extra logic
  localparam logic [63:0] ED_BIT =
    (ED_MODE == erc_pkg::CTL_COMBINED) ? 64'h1 : 64'h0;
  localparam logic [63:0] WMASK =
      ctl_bits(DUI_MODE, erc_pkg::BIT_DUI, erc_pkg::BIT_WRITE_DEFERRED_RECOVERY_IRQ_EN)
    | ctl_bits(CFI_MODE, erc_pkg::BIT_CFI, erc_pkg::BIT_WRITE_CORRECTED_FAULT_IRQ_EN)
    | ctl_bits(UE_MODE,  erc_pkg::BIT_UE,  erc_pkg::BIT_WUE)
    | ctl_bits(FI_MODE,  erc_pkg::BIT_FI,  erc_pkg::BIT_WFI)
    | ctl_bits(UI_MODE,  erc_pkg::BIT_UI,  erc_pkg::BIT_WUI)
    | ED_BIT
    | (IMPL_MASK & erc_pkg::IMPL_FIELD);
  localparam logic [63:0] RESET_VAL =
    ED_BIT & {63'h0, ED_RESET_VAL};

  // ----------------------------------------------------------------
  // the single shared copy
  // ----------------------------------------------------------------
  logic [63:0] ctrl;

  // ----------------------------------------------------------------
  // memory-mapped decode
  // ----------------------------------------------------------------
  localparam int RW = ADDR_W - erc_pkg::REC_SHIFT;
  localparam logic [RW-1:0] FIRST_R = RW'(NODE_FIRST);
  localparam logic [RW-1:0] LAST_R  = RW'(NODE_FIRST + NODE_RECS - 1);

  wire [RW-1:0] mm_rec = mm_addr[ADDR_W-1:erc_pkg::REC_SHIFT];
  wire          mm_slot =
    mm_addr[erc_pkg::REC_SHIFT-1:0] == erc_pkg::CTRL_IN_REC;
  wire          mm_in_node = mm_slot
                           & (mm_rec >= FIRST_R) & (mm_rec <= LAST_R);
  // later records of the node alias to nothing
  wire          mm_is_ctrl = mm_slot & (mm_rec == FIRST_R);
  wire          mm_take    = ce & mm_req;
  wire          mm_wr_hit  = mm_take & mm_write & mm_is_ctrl;
  wire [63:0]   mm_rd_val  = mm_is_ctrl ? ctrl : 64'h0;

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] FIRST_I = IDX_W'(NODE_FIRST);
  wire sr_is_ctrl = record_pick_index == FIRST_I;
  wire sr_take    = ce & sr_req;
  wire sr_wr_hit  = sr_take & sr_write & sr_is_ctrl;

  // lane mask chosen by the view in use
  wire [63:0] sr_lanes =
    (sr_view == erc_pkg::VIEW_LOW)  ? erc_pkg::LOW_HALF  :
    (sr_view == erc_pkg::VIEW_HIGH) ? erc_pkg::HIGH_HALF : '1;
  // half views carry their half in the low 32 bits of the data word
  wire [63:0] sr_wd =
    (sr_view == erc_pkg::VIEW_HIGH)
      ? {sr_wdata[erc_pkg::HALF_W-1:0], 32'h0} : sr_wdata;
  wire [63:0] sr_src   = sr_is_ctrl ? ctrl : 64'h0;
  wire [63:0] sr_rd_val =
    (sr_view == erc_pkg::VIEW_LOW)
      ? {32'h0, sr_src[erc_pkg::HALF_W-1:0]} :
    (sr_view == erc_pkg::VIEW_HIGH)
      ? {32'h0, sr_src[63:erc_pkg::HALF_W]} : sr_src;

  // ----------------------------------------------------------------
  // next value of the shared copy
  // ----------------------------------------------------------------
  // both paths in one cycle: the window write lands on top of the
  // memory write, so no update is lost on disjoint lanes
  wire [63:0] after_mm =
    mm_wr_hit ? merge(ctrl, mm_wdata, WMASK) : ctrl;
  wire [63:0] next_ctrl =
    sr_wr_hit ? merge(after_mm, sr_wd, WMASK & sr_lanes)
              : after_mm;

  // control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= RESET_VAL;
    end else if (ce) begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // access answers
  // ----------------------------------------------------------------
  // every request taken while ce is high is answered one edge later; misses read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mm_ack   <= 1'b0;
      mm_hit   <= 1'b0;
      mm_rdata <= '0;
    end else if (ce) begin
      mm_ack   <= mm_req;
      mm_hit   <= mm_req & mm_in_node;
      mm_rdata <= (mm_req & ~mm_write) ? mm_rd_val : 64'h0;
    end
  end

  // window answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_ack   <= 1'b0;
      sr_rdata <= '0;
    end else if (ce) begin
      sr_ack   <= sr_req;
      sr_rdata <= (sr_req & ~sr_write) ? sr_rd_val : 64'h0;
    end
  end

  // ----------------------------------------------------------------
  // effective enables
  // ----------------------------------------------------------------
  wire report_on = (ED_MODE == erc_pkg::CTL_ALWAYS)
                 | ctrl[erc_pkg::BIT_ED];

  wire erc_pkg::erc_en_t rd_en = '{
    ctl_en(DUI_MODE, ctrl, erc_pkg::BIT_DUI, erc_pkg::BIT_WRITE_DEFERRED_RECOVERY_IRQ_EN, 1'b0),
    ctl_en(CFI_MODE, ctrl, erc_pkg::BIT_CFI, erc_pkg::BIT_WRITE_CORRECTED_FAULT_IRQ_EN, 1'b0),
    ctl_en(UE_MODE,  ctrl, erc_pkg::BIT_UE,  erc_pkg::BIT_WUE,  1'b0),
    ctl_en(FI_MODE,  ctrl, erc_pkg::BIT_FI,  erc_pkg::BIT_WFI,  1'b0),
    ctl_en(UI_MODE,  ctrl, erc_pkg::BIT_UI,  erc_pkg::BIT_WUI,  1'b0)
  };
  wire erc_pkg::erc_en_t wr_en = '{
    ctl_en(DUI_MODE, ctrl, erc_pkg::BIT_DUI, erc_pkg::BIT_WRITE_DEFERRED_RECOVERY_IRQ_EN, 1'b1),
    ctl_en(CFI_MODE, ctrl, erc_pkg::BIT_CFI, erc_pkg::BIT_WRITE_CORRECTED_FAULT_IRQ_EN, 1'b1),
    ctl_en(UE_MODE,  ctrl, erc_pkg::BIT_UE,  erc_pkg::BIT_WUE,  1'b1),
    ctl_en(FI_MODE,  ctrl, erc_pkg::BIT_FI,  erc_pkg::BIT_WFI,  1'b1),
    ctl_en(UI_MODE,  ctrl, erc_pkg::BIT_UI,  erc_pkg::BIT_WUI,  1'b1)
  };

  // ----------------------------------------------------------------
  // event gating
  // ----------------------------------------------------------------
  erc_pkg::erc_signal_t sig;

  erc_event_gate #(
    .CFI_PRESENT    (CFI_MODE != erc_pkg::CTL_ABSENT),
    .HAS_CE_COUNTER (HAS_CE_COUNTER)
  ) u_gate (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .report_on (report_on),
    .rd_en     (rd_en),
    .wr_en     (wr_en),
    .ev        (err_event),
    .sig       (sig)
  );

  assign record_log   = sig.record_log;
  assign recovery_irq = sig.recovery_irq;
  assign fault_irq    = sig.fault_irq;
  assign abort_resp   = sig.abort_resp;

  // ----------------------------------------------------------------
  // overflow flag
  // ----------------------------------------------------------------
  // nothing is recorded while reporting is off, so the flag waits too
  wire ovf_set = err_event.valid & report_on & HAS_CE_COUNTER
               & (err_event.kind == erc_pkg::KIND_CE)
               & err_event.counter_wrap;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counter_overflow_flag <= 1'b0;
    end else if (ce) begin
      counter_overflow_flag <= ovf_set
                             | (counter_overflow_flag & ~overflow_clear);
    end
  end

  // ----------------------------------------------------------------
  // datapath controls
  // ----------------------------------------------------------------
  // codes stay correct while off unless the impl control stops them;
  // silent correction while off is a build choice
  wire next_check  = report_on | ~ctrl[erc_pkg::BIT_NOCHK];
  wire next_silent = report_on | SILENT_CORRECT;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      report_enable         <= 1'b0;
      check_gen_enable      <= 1'b1;
      silent_correct_enable <= 1'b0;
    end else if (ce) begin
      report_enable         <= report_on;
      check_gen_enable      <= next_check;
      silent_correct_enable <= next_silent;
    end
  end

endmodule // erc_ctrl_bank
`default_nettype wire

// file: design/erc_pkg.sv
package erc_pkg;

  // ----------------------------------------------------------------
  // map and layout
  // ----------------------------------------------------------------
  localparam int          REC_SHIFT     = 6;      // 64 bytes per record
  localparam logic [5:0]  CTRL_IN_REC   = 6'h08;  // offset inside record
  localparam logic [63:0] LOW_HALF      = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] HIGH_HALF     = 64'hffff_ffff_0000_0000;
  localparam logic [63:0] IMPL_FIELD    = 64'hffff_ffff_0000_0002;
  localparam int          HALF_W        = 32;

  localparam int BIT_ED    = 0;
  localparam int BIT_UI    = 2;
  localparam int BIT_FI    = 3;
  localparam int BIT_UE    = 4;
  localparam int BIT_WUI   = 5;
  localparam int BIT_WFI   = 6;
  localparam int BIT_WUE   = 7;
  localparam int BIT_CFI   = 8;
  localparam int BIT_WRITE_CORRECTED_FAULT_IRQ_EN  = 9;
  localparam int BIT_DUI   = 10;
  localparam int BIT_WRITE_DEFERRED_RECOVERY_IRQ_EN  = 11;
  localparam int BIT_NOCHK = 32;  // impl control: stop codes while off

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTL_ABSENT   = 2'h0,
    CTL_ALWAYS   = 2'h1,
    CTL_COMBINED = 2'h2,
    CTL_SPLIT    = 2'h3
  } erc_mode_t;

  typedef enum logic [1:0] {
    VIEW_LOW  = 2'h0,
    VIEW_HIGH = 2'h1,
    VIEW_FULL = 2'h2
  } erc_view_t;

  typedef enum logic [1:0] {
    KIND_CE = 2'h0,
    KIND_DE = 2'h1,
    KIND_UE = 2'h2
  } erc_kind_t;

  typedef struct packed {
    logic      valid;
    logic      is_write;
    erc_kind_t kind;
    logic      counter_wrap;  // this corrected error wrapped the counter
    logic      dropped;       // syndrome lost to a higher priority error
  } erc_event_t;

  typedef struct packed {
    logic deferred_recovery_irq_enable;
    logic corrected_fault_irq_enable;
    logic ue;
    logic fi;
    logic ui;
  } erc_en_t;

  typedef struct packed {
    logic record_log;
    logic recovery_irq;
    logic fault_irq;
    logic abort_resp;
  } erc_signal_t;

endpackage

// file: design/erc_event_gate.sv
`timescale 1ns/100ps
`default_nettype none
module erc_event_gate #(
  parameter bit CFI_PRESENT    = 1'b1,
  parameter bit HAS_CE_COUNTER = 1'b1
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               report_on,
  input  wire erc_pkg::erc_en_t   rd_en,
  input  wire erc_pkg::erc_en_t   wr_en,
  input  wire erc_pkg::erc_event_t ev,
  output erc_pkg::erc_signal_t    sig
);

  // ----------------------------------------------------------------
  // enable selection by direction
  // ----------------------------------------------------------------
  wire erc_pkg::erc_en_t en = ev.is_write ? wr_en : rd_en;
  wire live   = ev.valid & report_on;
  wire is_ce  = ev.kind == erc_pkg::KIND_CE;
  wire is_de  = ev.kind == erc_pkg::KIND_DE;
  wire is_ue  = ev.kind == erc_pkg::KIND_UE;
  // with a counter only the wrapping error counts as the trigger
  wire ce_hit = HAS_CE_COUNTER ? ev.counter_wrap : 1'b1;
  wire ce_en  = CFI_PRESENT ? en.corrected_fault_irq_enable : en.fi;

  // dropped only stops logging; every enabled signal still fires
  wire next_log   = live & ~ev.dropped;
  wire next_rec   = live & ((is_de & en.deferred_recovery_irq_enable)
                         | (is_ue & en.ui));
  wire next_fault = live & (((is_de | is_ue) & en.fi)
                         | (is_ce & ce_hit & ce_en));
  wire next_abort = live & is_ue & en.ue;

  // one-cycle pulses, registered so the top drives from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sig <= '0;
    end else if (ce) begin
      sig <= '{next_log, next_rec, next_fault, next_abort};
    end
  end

endmodule // erc_event_gate
`default_nettype wire

// file: sim/erc_ctrl_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the control bank
// ----------------------------------------------------------------
module erc_ctrl_bank_sva #(
  parameter int ADDR_W     = 16,
  parameter int IDX_W      = 8,
  parameter int NODE_FIRST = 0
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                ce,
  input wire logic                mm_req,
  input wire logic                mm_write,
  input wire logic [ADDR_W-1:0]   mm_addr,
  input wire logic [63:0]         mm_wdata,
  input wire logic [63:0]         mm_rdata,
  input wire logic                mm_ack,
  input wire logic                mm_hit,
  input wire logic [IDX_W-1:0]    record_pick_index,
  input wire logic                sr_req,
  input wire logic                sr_write,
  input wire erc_pkg::erc_view_t  sr_view,
  input wire logic [63:0]         sr_wdata,
  input wire logic [63:0]         sr_rdata,
  input wire logic                sr_ack,
  input wire erc_pkg::erc_event_t err_event,
  input wire logic                overflow_clear,
  input wire logic                record_log,
  input wire logic                recovery_irq,
  input wire logic                fault_irq,
  input wire logic                abort_resp,
  input wire logic                report_enable,
  input wire logic                check_gen_enable,
  input wire logic                silent_correct_enable,
  input wire logic                counter_overflow_flag
);
  // one clock domain, so clocking and reset are stated once
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_mm_ack_next: assert property (ce && mm_req |=> mm_ack)
    else $error("memory request without ack");
  a_sr_ack_next: assert property (ce && sr_req |=> sr_ack)
    else $error("window request without ack");
  a_miss_reads_zero: assert property (
      mm_ack && !mm_hit |-> mm_rdata == 64'h0)
    else $error("miss returned data");
  a_other_rec_zero: assert property (ce && sr_req &&
      record_pick_index != IDX_W'(NODE_FIRST) |=> sr_rdata == 64'h0)
    else $error("other record read not zero");
  a_reserved_zero: assert property (mm_ack |->
      mm_rdata[31:12] == 20'h0 && mm_rdata[11] == 1'b0
      && mm_rdata[9] == 1'b0 && mm_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  a_half_upper_zero: assert property (sr_ack && $past(ce) &&
      $past(sr_view) != erc_pkg::VIEW_FULL |-> sr_rdata[63:32] == 32'h0)
    else $error("half view upper word nonzero");
  // report_enable lags the control by one edge, so it is read one
  // cycle after the event, beside the pulses from the same control
  a_off_no_signal: assert property (ce && err_event.valid
      ##1 !report_enable
      |-> !(record_log || recovery_irq || fault_irq || abort_resp))
    else $error("signal while reporting off");
  a_abort_cause: assert property ($past(ce) && abort_resp |->
      $past(err_event.valid && err_event.kind == erc_pkg::KIND_UE))
    else $error("abort without uncorrected error");
  a_drop_no_log: assert property (ce && err_event.valid
      && err_event.dropped |=> !record_log)
    else $error("dropped syndrome logged");
  a_wrap_sets_flag: assert property (ce && err_event.valid &&
      err_event.kind == erc_pkg::KIND_CE && err_event.counter_wrap
      ##1 report_enable |-> counter_overflow_flag)
    else $error("overflow flag not set");
  a_codes_when_on: assert property (
      report_enable |-> check_gen_enable)
    else $error("check codes off while reporting");
endmodule // erc_ctrl_bank_sva

bind erc_ctrl_bank erc_ctrl_bank_sva #(
  .ADDR_W(ADDR_W),
  .IDX_W(IDX_W),
  .NODE_FIRST(NODE_FIRST)
) u_sva (.*);
`default_nettype wire

// file: sim/test_erc_ctrl_bank.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// register and event tests through both access paths
// ----------------------------------------------------------------
module test_erc_ctrl_bank;
  logic clock, rst, ce, mm_req, mm_write, mm_ack, mm_hit, sr_req, sr_write;
  logic [15:0] mm_addr;
  logic [63:0] mm_wdata, mm_rdata, sr_wdata, sr_rdata, rd, c;
  logic [7:0]  record_pick_index;
  erc_pkg::erc_view_t  sr_view;
  erc_pkg::erc_event_t err_event;
  erc_pkg::erc_signal_t ex;
  logic overflow_clear, record_log, recovery_irq, fault_irq, abort_resp;
  logic report_enable, check_gen_enable, silent_correct_enable;
  logic counter_overflow_flag, sr_ack;
  int   n_errors, checks_done;
  logic [63:0] ctl_tab [6] = '{64'h51d, 64'h405, 64'h109, 64'h011,
                               64'h51c, 64'h0};

  erc_ctrl_bank u_dut (.*);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one access on either path; answer is taken one edge after the request
  task automatic acc(input logic win, input logic wr, input logic [15:0] a,
                     input erc_pkg::erc_view_t v, input logic [63:0] wd,
                     output logic [63:0] r);
    @(posedge clock);
    mm_req <= !win;
    sr_req <= win;
    mm_write <= wr;
    sr_write <= wr;
    mm_addr <= a;
    sr_view <= v;
    mm_wdata <= wd;
    sr_wdata <= wd;
    @(posedge clock);
    mm_req <= 1'b0;
    sr_req <= 1'b0;
    #1;
    chk({63'h0, win ? sr_ack : mm_ack}, 64'h1, "ack");
    r = win ? sr_rdata : mm_rdata;
  endtask

  // expected pulses worked out from the control word in combined mode
  function automatic erc_pkg::erc_signal_t want(input logic [63:0] w,
                                                input erc_pkg::erc_event_t e);
    erc_pkg::erc_signal_t s;
    logic de, ue, cw;
    de = e.kind == erc_pkg::KIND_DE;
    ue = e.kind == erc_pkg::KIND_UE;
    cw = e.kind == erc_pkg::KIND_CE && e.counter_wrap;
    s.record_log = w[0] & !e.dropped;
    s.recovery_irq = w[0] & ((de & w[10]) | (ue & w[2]));
    s.fault_irq = w[0] & (((de | ue) & w[3]) | (cw & w[8]));
    s.abort_resp = w[0] & ue & w[4];
    return s;
  endfunction

  // flag clear rides after each event so every event starts from a clear flag
  task automatic fire(input erc_pkg::erc_event_t e);
    @(posedge clock);
    err_event <= e;
    overflow_clear <= 1'b0;
    @(posedge clock);
    err_event <= '0;
    overflow_clear <= 1'b1;
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    conclude();
  end

  initial begin
    {rst, ce, mm_req, mm_write, sr_req, sr_write, overflow_clear} = 7'h61;
    mm_addr = 16'h0;
    {mm_wdata, sr_wdata} = '0;
    record_pick_index = 8'h0;
    sr_view = erc_pkg::VIEW_FULL;
    err_event = '0;
    rst = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    acc(0, 0, 16'h008, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h0, "cold value");
    chk({63'h0, mm_hit}, 64'h1, "hit");
    chk({63'h0, report_enable}, 64'h0, "reporting off");
    $display("reset test done");
    acc(0, 1, 16'h008, erc_pkg::VIEW_FULL, '1, rd);
    acc(0, 0, 16'h008, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h1_0000_051d, "writable mask");
    acc(1, 0, 16'h0, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h1_0000_051d, "window full");
    acc(1, 0, 16'h0, erc_pkg::VIEW_LOW, 64'h0, rd);
    chk(rd, 64'h51d, "window low");
    acc(1, 0, 16'h0, erc_pkg::VIEW_HIGH, 64'h0, rd);
    chk(rd, 64'h1, "window high");
    acc(1, 1, 16'h0, erc_pkg::VIEW_LOW, 64'h0, rd);
    acc(1, 1, 16'h0, erc_pkg::VIEW_HIGH, 64'hffff_ffff, rd);
    acc(0, 0, 16'h008, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h1_0000_0000, "window write seen");
    chk({61'h0, report_enable, check_gen_enable, silent_correct_enable},
        64'h1, "off with codes stopped");
    $display("register test done");
    acc(0, 1, 16'h048, erc_pkg::VIEW_FULL, '1, rd);
    acc(0, 0, 16'h048, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h0, "second record");
    chk({63'h0, mm_hit}, 64'h1, "second record hit");
    acc(0, 0, 16'h010, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h0, "unmapped");
    chk({63'h0, mm_hit}, 64'h0, "unmapped hit");
    record_pick_index <= 8'h1;
    acc(1, 1, 16'h0, erc_pkg::VIEW_FULL, '1, rd);
    acc(1, 0, 16'h0, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h0, "window second record");
    record_pick_index <= 8'h0;
    acc(1, 0, 16'h0, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h1_0000_0000, "first record kept");
    $display("record test done");
    foreach (ctl_tab[i]) begin
      c = ctl_tab[i];
      acc(0, 1, 16'h008, erc_pkg::VIEW_FULL, c, rd);
      // the effective enable is registered one edge behind the control
      @(posedge clock);
      #1;
      chk({63'h0, report_enable}, {63'h0, c[0]}, "enable");
      for (int k = 0; k < 3; k++) begin
        for (int w = 0; w < 2; w++) begin
          fire('{1'b1, w[0], erc_pkg::erc_kind_t'(k), !w[0], w[0]});
          ex = want(c, '{1'b1, w[0], erc_pkg::erc_kind_t'(k), !w[0], w[0]});
          chk({60'h0, record_log, recovery_irq, fault_irq, abort_resp},
              64'(ex), "pulses");
          chk({63'h0, counter_overflow_flag},
              {63'h0, c[0] && k == 0 && w == 0}, "flag");
        end
      end
    end
    $display("event test done");
    // a request while the clock enable is low must leave no trace
    @(posedge clock);
    ce <= 1'b0;
    {mm_req, mm_write, mm_addr, mm_wdata} <= {2'h3, 16'h008, 64'h1};
    repeat (2) @(posedge clock);
    #1;
    chk({63'h0, mm_ack}, 64'h0, "frozen ack");
    @(posedge clock);
    mm_req <= 1'b0;
    ce <= 1'b1;
    acc(0, 0, 16'h008, erc_pkg::VIEW_FULL, 64'h0, rd);
    chk(rd, 64'h0, "frozen write dropped");
    $display("freeze test done");
    conclude();
  end
endmodule // test_erc_ctrl_bank
`default_nettype wire
